// ===== core/tipc_top.sv
// Trap and interrupt priority controller: flags, enables, priorities, arbitration, CPU level.
// Assumes a core that acknowledges the offered request and restores its level on return.
//
// How it works
// [RULE_01] Eight trap vectors, primary and alternate tables; traps 1..5 implemented.
// [RULE_02] Each source has a flag, set by hardware, cleared by software write.
// [RULE_03] Each source has its own enable bit.
// [RULE_04] Each source gets a three-bit priority, eight levels.
// [RULE_05] Pending vector and its level are latched into a status register.
// [RULE_06] Flag, enable, priority positions follow vector order, source zero first.
// [RULE_07] Status word bits 7..5 hold and accept the low CPU level.
// [RULE_08] Fourth level bit lives in core control; software cannot set it.
// [RULE_09] Low level field 111 blocks all user interrupts.
// [RULE_10] Fourth level bit set blocks all user interrupts.
// [RULE_11] Nesting disable makes the status level bits read-only.
// [RULE_12] First control register holds nesting disable and trap flags.
// [RULE_13] Second control register holds pin edge select and table select.
// [RULE_14] Thirty-one registers: two control, five flag, five enable, eighteen priority, one pending.
// [RULE_15] Highest priority above CPU level wins; ties go to lower vector.
//
// The register offsets and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
`include "tipc_params.svh"
module tipc_top (
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire logic [7:0]        regAddr,
  input  wire logic [15:0]       regWrData,
  input  wire logic              regWr,
  input  wire logic              regRd,
  output logic      [15:0]       regRdData,
  input  wire logic [71:0]       srcReq,
  input  wire logic [4:0]        extPin,
  input  wire logic [7:0]        trapReq,
  input  wire logic              coreAck,
  input  wire logic              coreLevelLoad,
  input  wire logic [3:0]        coreLevelIn,
  output tipc_pkg::tipc_irq_t    irqOut,
  output logic      [3:0]        cpuLevel
);

  function automatic logic inRange(input logic [7:0] a, input logic [7:0] b,
                                   input logic [7:0] n);
    inRange = (a >= b) && (a < b + n);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic                 nesting_disable_q;
  logic [7:0]           trapFlag_q;
  logic                 altIvt_q;
  logic [4:0]           extEdge_q;
  logic [4:0]           extPrev_q;
  logic [71:0]          flag_q;
  logic [71:0]          en_q;
  logic [2:0]           prio_q [72];
  logic [3:0]           cpuLevel_q;
  tipc_pkg::tipc_pend_t pend_q;
  tipc_pkg::tipc_irq_t  irq_q;
  logic [15:0]          rd_q;

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  wire wrCtlA = regWr && (regAddr == `TIPC_A_CTLA); // RULE_12
  wire wrCtlB = regWr && (regAddr == `TIPC_A_CTLB); // RULE_13
  wire wrSr   = regWr && (regAddr == `TIPC_A_SR);
  wire wrCore = regWr && (regAddr == `TIPC_A_CORE);
  wire ackTaken = coreAck && irq_q.valid;

  ////////////////////////////////////////////////////////////////////////////
  // External pins: polarity 0 rising, 1 falling
  wire [4:0] extHit = (extEdge_q & extPrev_q & ~extPin) |
                      (~extEdge_q & ~extPrev_q & extPin); // RULE_13
  logic [71:0] extSet;
  always_comb begin
    extSet                 = '0;
    extSet[`TIPC_EXT0_IDX] = extHit[0];
    extSet[`TIPC_EXT1_IDX] = extHit[1];
    extSet[`TIPC_EXT2_IDX] = extHit[2];
    extSet[`TIPC_EXT3_IDX] = extHit[3];
    extSet[`TIPC_EXT4_IDX] = extHit[4];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-source flag, enable and priority
  genvar gi;
  generate
    for (gi = 0; gi < `TIPC_NSRC; gi++) begin : g_src
      localparam logic [7:0] FW = 8'(gi / 16);
      localparam logic [7:0] PW = 8'(gi / 4);
      localparam int         FB = gi % 16;
      localparam int         PB = 4 * (gi % 4);
      wire wrFlag = regWr && (regAddr == `TIPC_A_FLAG0 + FW);
      wire wrEn   = regWr && (regAddr == `TIPC_A_EN0 + FW);
      wire wrPrio = regWr && (regAddr == `TIPC_A_PRIO0 + PW);
      wire setIt  = srcReq[gi] | extSet[gi];
      // Set wins over a clearing write in the same cycle
      wire flagD  = setIt | (wrFlag ? regWrData[FB] : flag_q[gi]); // RULE_02 RULE_06
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          flag_q[gi] <= 1'b0;
          en_q[gi]   <= 1'b0;
          prio_q[gi] <= 3'h0;
        end else begin
          flag_q[gi] <= flagD;
          if (wrEn) en_q[gi] <= regWrData[FB]; // RULE_03
          if (wrPrio) prio_q[gi] <= regWrData[PB +: 3]; // RULE_04
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // CPU level
  wire [2:0] iplWr   = regWrData[`TIPC_SR_IPL_LSB +: 3];
  wire       ipl3Clr = wrCore && !regWrData[`TIPC_CPU_PRIORITY_HIGH_BIT_BIT];
  logic [3:0] cpuLevel_d;
  always_comb begin
    cpuLevel_d = cpuLevel_q;
    if (coreLevelLoad) begin
      cpuLevel_d = coreLevelIn;
    end else if (ackTaken) begin
      cpuLevel_d = irq_q.level;
    end else begin
      if (wrSr && !nesting_disable_q) cpuLevel_d[2:0] = iplWr; // RULE_07 RULE_11
      // Only a clear reaches the high bit from software
      if (ipl3Clr) cpuLevel_d[3] = 1'b0; // RULE_08
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Arbitration
  logic [2:0] bestPrio;
  logic [6:0] bestIdx;
  logic       bestHit;
  always_comb begin
    bestPrio = 3'h0;
    bestIdx  = 7'h00;
    bestHit  = 1'b0;
    for (int i = 0; i < `TIPC_NSRC; i++) begin
      // Strict compare keeps the lower vector on a tie
      if (flag_q[i] && en_q[i] && prio_q[i] > bestPrio) begin // RULE_15
        bestPrio = prio_q[i];
        bestIdx  = 7'(i);
        bestHit  = 1'b1;
      end
    end
  end

  wire userBlocked = cpuLevel_d[3] || (cpuLevel_d[2:0] == 3'h7); // RULE_09 RULE_10
  wire userOk = bestHit && !userBlocked && ({1'b0, bestPrio} > cpuLevel_d); // RULE_15

  wire [7:0] trapLive = trapFlag_q & `TIPC_TRAP_MASK;
  logic [2:0] trapIdx;
  always_comb begin
    trapIdx = 3'h0;
    for (int t = 7; t >= 0; t--) begin
      if (trapLive[t]) trapIdx = 3'(t);
    end
  end
  // Traps rank above all user sources; lower trap number ranks higher
  wire [3:0] trapLvl = `TIPC_TOP_LEVEL - {1'b0, trapIdx};
  wire trapOk = (trapLive != 8'h00) && (trapLvl > cpuLevel_d);

  wire [6:0] selVec = trapOk ? {4'h0, trapIdx} : (`TIPC_USER_VEC0 + bestIdx);
  wire [3:0] selLvl = trapOk ? trapLvl : {1'b0, bestPrio};
  wire       selOk  = trapOk || userOk;
  wire [23:0] tblBase = altIvt_q ? `TIPC_ALTERNATE_VECTOR_TABLE_BASE : `TIPC_IVT_BASE; // RULE_13
  wire [23:0] selAddr = tblBase + {16'h0000, selVec, 1'b0}; // RULE_01

  ////////////////////////////////////////////////////////////////////////////
  // Read view
  wire [79:0] flagView = {8'h00, flag_q};
  wire [79:0] enView   = {8'h00, en_q};
  wire [7:0]  flagW    = regAddr - `TIPC_A_FLAG0;
  wire [7:0]  enW      = regAddr - `TIPC_A_EN0;
  wire [7:0]  prioW    = regAddr - `TIPC_A_PRIO0;
  logic [15:0] prioWord;
  always_comb begin
    prioWord = 16'h0000;
    for (int j = 0; j < 4; j++) begin
      if (prioW < 8'(`TIPC_NPRIOW)) prioWord[4*j +: 3] = prio_q[4*prioW + j];
    end
  end
  logic [15:0] rd_d;
  always_comb begin
    rd_d = 16'h0000;
    if (regAddr == `TIPC_A_CTLA) begin
      rd_d = {nesting_disable_q, 7'h00, trapFlag_q & `TIPC_TRAP_MASK}; // RULE_12
    end else if (regAddr == `TIPC_A_CTLB) begin
      rd_d = {altIvt_q, 10'h000, extEdge_q};
    end else if (inRange(regAddr, `TIPC_A_FLAG0, 8'(`TIPC_NFLAGW))) begin
      rd_d = flagView[16*flagW[2:0] +: 16];
    end else if (inRange(regAddr, `TIPC_A_EN0, 8'(`TIPC_NFLAGW))) begin
      rd_d = enView[16*enW[2:0] +: 16];
    end else if (inRange(regAddr, `TIPC_A_PRIO0, 8'(`TIPC_NPRIOW))) begin
      rd_d = prioWord;
    end else if (regAddr == `TIPC_A_PVS) begin
      rd_d = {4'h0, pend_q.level, 1'b0, pend_q.vector}; // RULE_05
    end else if (regAddr == `TIPC_A_SR) begin
      rd_d = {8'h00, cpuLevel_q[2:0], 5'h00}; // RULE_07
    end else if (regAddr == `TIPC_A_CORE) begin
      rd_d = {12'h000, cpuLevel_q[3], 3'h0}; // RULE_08
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers and trap flags
  wire [7:0] trapD = (trapReq & `TIPC_TRAP_MASK) |
                     (wrCtlA ? regWrData[7:0] & `TIPC_TRAP_MASK : trapFlag_q); // RULE_01
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      nesting_disable_q   <= 1'b0;
      trapFlag_q <= 8'h00;
      altIvt_q   <= 1'b0;
      extEdge_q  <= 5'h00;
      extPrev_q  <= 5'h00;
    end else begin
      trapFlag_q <= trapD;
      extPrev_q  <= extPin;
      if (wrCtlA) nesting_disable_q <= regWrData[`TIPC_NESTING_DISABLE_BIT]; // RULE_12
      if (wrCtlB) begin
        altIvt_q  <= regWrData[`TIPC_ALTIVT_BIT];
        extEdge_q <= regWrData[4:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Level, pending status, offer and read data
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cpuLevel_q <= `TIPC_LEVEL_RST;
      pend_q     <= '0;
      irq_q      <= '0;
      rd_q       <= 16'h0000;
    end else begin
      cpuLevel_q <= cpuLevel_d;
      if (selOk) pend_q <= '{vector: selVec, level: selLvl}; // RULE_05
      irq_q <= '{valid: selOk, vector: selVec, level: selLvl, addr: selAddr};
      if (regRd) rd_q <= rd_d; // RULE_14
    end
  end

  assign regRdData = rd_q;
  assign irqOut    = irq_q;
  assign cpuLevel  = cpuLevel_q;

endmodule // tipc_top

// ===== common/tipc_params.svh
// Offsets, field positions, reset values and constants of the trap and interrupt controller.
// Assumes a word-indexed register port with 16-bit data.
`ifndef TIPC_PARAMS_SVH
`define TIPC_PARAMS_SVH
`define TIPC_NSRC        72
`define TIPC_NFLAGW      5
`define TIPC_NPRIOW      18
`define TIPC_A_CTLA      8'h00
`define TIPC_A_CTLB      8'h01
`define TIPC_A_FLAG0     8'h02
`define TIPC_A_EN0       8'h07
`define TIPC_A_PRIO0     8'h0C
`define TIPC_A_PVS       8'h1E
`define TIPC_A_SR        8'h1F
`define TIPC_A_CORE      8'h20
`define TIPC_NESTING_DISABLE_BIT  15
`define TIPC_ALTIVT_BIT  15
`define TIPC_SR_IPL_LSB  5
`define TIPC_CPU_PRIORITY_HIGH_BIT_BIT    3
`define TIPC_PVS_LVL_LSB 8
`define TIPC_TRAP_MASK   8'h3E
`define TIPC_IVT_BASE    24'h000004
`define TIPC_ALTERNATE_VECTOR_TABLE_BASE   24'h000104
`define TIPC_USER_VEC0   7'h08
`define TIPC_TOP_LEVEL   4'hF
`define TIPC_LEVEL_RST   4'h0
`define TIPC_EXT0_IDX    0
`define TIPC_EXT1_IDX    20
`define TIPC_EXT2_IDX    29
`define TIPC_EXT3_IDX    53
`define TIPC_EXT4_IDX    54
`endif

// ===== common/tipc_pkg.sv
// Types shared by the trap and interrupt controller.
// Assumes the constants header is available on the include path.
package tipc_pkg;
  typedef struct packed {
    logic        valid;
    logic [6:0]  vector;
    logic [3:0]  level;
    logic [23:0] addr;
  } tipc_irq_t;
  typedef struct packed {
    logic [6:0] vector;
    logic [3:0] level;
  } tipc_pend_t;
endpackage

// ===== tb/tipc_top_assertions.sv
// Port-level checks for the trap and interrupt priority controller.
// Assumes it is bound onto tipc_top, all inputs named as the top's ports.
`timescale 1ns/1ps
`include "tipc_params.svh"
module tipc_chk (
  input wire logic          sys_clk,
  input wire logic          rst,
  input wire logic [7:0]    regAddr,
  input wire logic          regRd,
  input wire logic [15:0]   regRdData,
  input wire logic          coreAck,
  input wire logic          coreLevelLoad,
  input tipc_pkg::tipc_irq_t irqOut,
  input wire logic [3:0]    cpuLevel
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  property p_ack; coreAck && irqOut.valid && !coreLevelLoad |=> cpuLevel == $past(irqOut.level);
  endproperty
  a_ack: assert property (p_ack) else $error("level after ack wrong");
  property p_above; irqOut.valid && $stable(cpuLevel) |-> irqOut.level > cpuLevel; endproperty
  a_above: assert property (p_above) else $error("offer not above level");
  property p_high; irqOut.valid && cpuLevel[3] && $past(cpuLevel[3]) |-> irqOut.vector < 7'h08;
  endproperty
  a_high: assert property (p_high) else $error("user offer at high level");
  property p_addr; irqOut.valid |-> irqOut.addr[23:9] == 15'h0000
    && irqOut.addr[7:0] == 8'h04 + {irqOut.vector, 1'b0}; endproperty
  a_addr: assert property (p_addr) else $error("vector address wrong");
  property p_trap; irqOut.valid && irqOut.vector < 7'h08 |-> irqOut.vector inside {[7'h01:7'h05]}
    && irqOut.level == 4'hF - irqOut.vector[3:0]; endproperty
  a_trap: assert property (p_trap) else $error("trap offer wrong");
  property p_user; irqOut.valid && irqOut.vector >= 7'h08 |-> !irqOut.level[3]; endproperty
  a_user: assert property (p_user) else $error("user level too high");
  property p_unmap; regRd && regAddr > 8'h20 |=> regRdData == 16'h0000; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_srlvl; regRd && regAddr == `TIPC_A_SR |=> regRdData[7:5] == $past(cpuLevel[2:0]);
  endproperty
  a_srlvl: assert property (p_srlvl) else $error("status level read wrong");
endmodule // tipc_chk

// ===== tb/tipc_core_model.sv
// Behavioural core: takes an offered request while the bench opens its window.
// Assumes the bench sets ackEn to choose prompt or late acceptance.
`timescale 1ns/1ps
module tipc_core_model (
  input wire logic           sys_clk,
  input wire logic           rst,
  input wire logic           ackEn,
  input tipc_pkg::tipc_irq_t irqOut,
  output logic               coreAck
);
  // Gap after each pulse so one offer is never taken twice
  always_ff @(posedge sys_clk) begin
    coreAck <= !rst && ackEn && irqOut.valid && !coreAck;
  end
endmodule // tipc_core_model

// ===== tb/tb.sv
// Bench for the trap and interrupt priority controller.
// Assumes the constants header on the include path and the core model beside it.
`timescale 1ns/1ps
`include "tipc_params.svh"
module tb;
  logic sys_clk = '0, rst = '1, regWr = '0, regRd = '0, coreLevelLoad = '0, ackEn = '0, coreAck;
  logic [7:0]  regAddr = '0, trapReq = '0;
  logic [15:0] regWrData = '0, regRdData;
  logic [71:0] srcReq = '0;
  logic [4:0]  extPin = '0;
  logic [3:0]  coreLevelIn = '0, cpuLevel;
  tipc_pkg::tipc_irq_t irqOut;
  int n_fail = 0, n_tests = 0, seed = 35524, i, j, p;
  always #2.5 sys_clk = ~sys_clk;
  tipc_top dut_u (.*);
  tipc_core_model core_u (.*);
  ////////////////////////////////////////
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge sys_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= v;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
    @(posedge sys_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1 chk(40'(regRdData & m), 40'(e));
  endtask
  task automatic fill(input logic [7:0] a, input int n, input logic [15:0] v);
    for (int k = 0; k < n; k++) wr(a + 8'(k), v);
  endtask
  task automatic setEn(input logic [79:0] e);
    for (int k = 0; k < 5; k++) wr(`TIPC_A_EN0 + 8'(k), e[16*k +: 16]);
  endtask
  task automatic chkIrq(input logic v, input logic [6:0] vec, input logic [3:0] lv, input logic alt);
    repeat (2) @(posedge sys_clk);
    #1 chk(v ? 40'(irqOut) : 40'(irqOut.valid),
      v ? 40'({v, vec, lv, (alt ? `TIPC_ALTERNATE_VECTOR_TABLE_BASE : `TIPC_IVT_BASE) + {vec, 1'b0}}) : 40'h0);
  endtask
  task automatic pulse(input logic [71:0] s, input logic [7:0] t);
    @(posedge sys_clk);
    srcReq <= s;
    trapReq <= t;
    @(posedge sys_clk);
    srcReq <= '0;
    trapReq <= '0;
  endtask
  task automatic ackWin();
    @(posedge sys_clk);
    ackEn <= 1'b1;
    repeat (4) @(posedge sys_clk);
    ackEn <= 1'b0;
  endtask
  task automatic wrap_up();
    $display("tests %0d fails %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    #100000;
    n_fail++;
    wrap_up();
  end
  initial begin
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    for (i = 0; i < 34; i++) rc(8'(i), 16'hFFFF, 16'h0000);
    wr(8'h21, 16'hFFFF);
    rc(8'h21, 16'hFFFF, 16'h0000);
    @(posedge sys_clk);
    extPin <= 5'h01;
    rc(`TIPC_A_FLAG0, 16'h0001, 16'h0001);
    // Falling-edge mode on pin zero, otherwise never exercised
    wr(`TIPC_A_FLAG0, 16'h0000);
    wr(`TIPC_A_CTLB, 16'h0001);
    rc(`TIPC_A_CTLB, 16'hFFFF, 16'h0001);
    rc(`TIPC_A_FLAG0, 16'h0001, 16'h0000);
    @(posedge sys_clk);
    extPin <= 5'h00;
    rc(`TIPC_A_FLAG0, 16'h0001, 16'h0001);
    for (int n = 0; n < 6; n++) begin
      i = $unsigned($random(seed)) % 71;
      j = i + 1 + $unsigned($random(seed)) % (71 - i);
      p = 1 + $unsigned($random(seed)) % 7;
      fill(`TIPC_A_FLAG0, 5, 16'h0000);
      wr(`TIPC_A_SR, 16'h0000);
      fill(`TIPC_A_PRIO0, 18, {4{1'b0, p[2:0]}});
      setEn(80'h1 << j);
      pulse((72'h1 << i) | (72'h1 << j), 8'h00);
      rc(`TIPC_A_FLAG0 + 8'(i / 16), 16'h1 << (i % 16), 16'h1 << (i % 16));
      chkIrq(1'b1, 7'(8 + j), 4'(p), 1'b0);
      setEn((80'h1 << i) | (80'h1 << j));
      chkIrq(1'b1, 7'(8 + i), 4'(p), 1'b0);
      wr(`TIPC_A_SR, 16'(p) << 5);
      chkIrq(1'b0, 7'h00, 4'h0, 1'b0);
      wr(`TIPC_A_SR, 16'(p - 1) << 5);
      chkIrq(1'b1, 7'(8 + i), 4'(p), 1'b0);
    end
    fill(`TIPC_A_PRIO0, 18, 16'h7777);
    wr(`TIPC_A_SR, 16'h00E0);
    chkIrq(1'b0, 7'h00, 4'h0, 1'b0);
    wr(`TIPC_A_CTLA, 16'h8000);
    wr(`TIPC_A_SR, 16'h0000);
    rc(`TIPC_A_SR, 16'hFFFF, 16'h00E0);
    wr(`TIPC_A_CTLA, 16'h0000);
    wr(`TIPC_A_SR, 16'h0000);
    chkIrq(1'b1, 7'(8 + i), 4'h7, 1'b0);
    for (int t = 1; t < 6; t++) begin
      wr(`TIPC_A_CTLB, 16'(t % 2) << 15);
      pulse(72'h0, 8'h1 << t);
      chkIrq(1'b1, 7'(t), 4'(15 - t), 1'(t % 2));
      rc(`TIPC_A_CTLA, 16'h003E, 16'h1 << t);
      if (t < 5) wr(`TIPC_A_CTLA, 16'h0000);
    end
    ackWin();
    #1 chk(40'(cpuLevel), 40'hA);
    rc(`TIPC_A_PVS, 16'h0F7F, 16'h0A05);
    rc(`TIPC_A_CORE, 16'h0008, 16'h0008);
    chkIrq(1'b0, 7'h00, 4'h0, 1'b0);
    wr(`TIPC_A_CORE, 16'h0000);
    #1 chk(40'(cpuLevel), 40'h2);
    wr(`TIPC_A_CTLA, 16'h0000);
    wr(`TIPC_A_CORE, 16'h0008);
    rc(`TIPC_A_CORE, 16'h0008, 16'h0000);
    chkIrq(1'b1, 7'(8 + i), 4'h7, 1'b1);
    ackWin();
    #1 chk(40'(cpuLevel), 40'h7);
    @(posedge sys_clk);
    coreLevelLoad <= 1'b1;
    coreLevelIn <= 4'h3;
    @(posedge sys_clk);
    coreLevelLoad <= 1'b0;
    #1 chk(40'(cpuLevel), 40'h3);
    wrap_up();
  end
endmodule // tb
bind tipc_top tipc_chk chk_u (.*);
